/* File: hw/sfr_regs.svh */
// constants of the serial memory front end: opcodes, status bits, timing
// assumes inclusion by bare name from every design file that needs them
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

`define SFR_OP_SET_LATCH 8'h06
`define SFR_OP_CLR_LATCH 8'h04
`define SFR_OP_STS_RD 8'h05
`define SFR_OP_STS_WR 8'h01
`define SFR_OP_MEM_LO 2'h1
`define SFR_OP_MEM_HI 4'h0
`define SFR_OP_A8 3
`define SFR_OP_RD_BIT 0
`define SFR_OP_MEM_BIT 1

`define SFR_SR_LATCH 1
`define SFR_SR_BP_HI 3
`define SFR_SR_BP_LO 2
`define SFR_SR_FILL 4'h0
`define SFR_BIT_LAST 3'h7
`define SFR_ADDR_ONE 9'h001
// idle pin levels: select high, hold high, clock low, input high
`define SFR_SYNC_RST 4'hD

`define SFR_CLK_NS 10
`define SFR_SCK_HALF_NS 80
`define SFR_HALF_CYC \
   (4'((`SFR_SCK_HALF_NS + `SFR_CLK_NS - 1) / `SFR_CLK_NS - 1))

`endif

/* File: hw/sfr_pkg.sv */
// types of the serial memory front end
// assumes the constants header is compiled alongside
package sfr_pkg;
   typedef enum logic [2:0] {
      SFR_D_IDLE = 3'b000,
      SFR_D_CMD = 3'b001,
      SFR_D_ADDR = 3'b010,
      SFR_D_WDATA = 3'b011,
      SFR_D_RDATA = 3'b100,
      SFR_D_SROUT = 3'b101,
      SFR_D_SRIN = 3'b110,
      SFR_D_IGNORE = 3'b111
   } sfr_dev_st_t;

   typedef enum logic [2:0] {
      SFR_H_IDLE = 3'b000,
      SFR_H_LEAD = 3'b001,
      SFR_H_LOW = 3'b010,
      SFR_H_HIGH = 3'b011,
      SFR_H_TRAIL = 3'b100,
      SFR_H_GAP = 3'b101
   } sfr_host_st_t;
endpackage

/* File: hw/sfr_if.sv */
// serial link between the bus master end and the memory front end
// assumes a pull-up on the serial output line when nobody drives it
`timescale 1ns/1ps
interface sfr_if;
   logic cs_n;
   logic sck;
   logic si;
   logic hold_n;
   logic so;
   logic so_oe;
   logic miso;

   // resolved serial output wire, high when released
   assign miso = so_oe ? so : 1'b1;

   modport dev (input cs_n, input sck, input si, input hold_n,
                output so, output so_oe);
   modport host (output cs_n, output sck, output si, output hold_n,
                 input miso);
endinterface

/* File: hw/sfr_sync.sv */
// two flip-flop synchroniser for a group of pin levels
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
module sfr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST;
         q <= RST;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

/* File: hw/sfr_dev.sv */
// memory end of the serial link: framing, opcode decode, address, latch
// assumes a byte memory on the user side answering mem_re one cycle later
// Operation
// - sample on rising, drive on falling
// - first byte of selection is opcode
// - one command per select low period
// - deselected: ignore input, release output
// - all bytes shift most significant first
// - opcode bit 3 is address bit 8
// - unknown opcode: ignore until next select
// - clock level at select picks mode
// - mode 3 first sample after low
// - master idles clock per chosen mode
// - decode latch and status write opcodes
// - status read shifts status byte out
// - latch clear after power-up
// - status write clears latch flag at deselect
// - clear latch at deselect after writes
// - latch clear command blocks writes
// - master waits power-up time first; sfr_host has no such wait and starts a frame on the first start after reset
// - master keeps clock under top rate
// - latch shown in status bit 1
// - burst address increments and wraps
// - hold low suspends and releases output
`timescale 1ns/1ps
`include "sfr_regs.svh"
module sfr_dev (
   input wire logic clk,
   input wire logic rst_n,
   sfr_if.dev link,
   output logic [8:0] mem_addr_q,
   output logic [7:0] mem_wdata_q,
   output logic mem_we_q,
   output logic mem_re_q,
   input wire logic [7:0] mem_rdata,
   output logic write_enable_flag_q,
   output logic [7:0] status_q,
   output logic spi_mode3_q
);
   logic s_cs_n;
   logic s_sck;
   logic s_si;
   logic s_hold_n;
   logic cs_prev_q;
   logic sck_prev_q;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic byte_done;
   logic [2:0] cnt_q;
   logic [7:0] rx_q;
   logic [7:0] rx_d;
   logic [7:0] tx_q;
   logic [1:0] bp_q;
   logic is_read_q;
   logic inc_q;
   logic load_q;
   logic clr_pend_q;
   logic op_mem;
   logic [7:0] sts;
   sfr_pkg::sfr_dev_st_t st_q;

   sfr_sync #(.W(4), .RST(`SFR_SYNC_RST)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({link.cs_n, link.hold_n, link.sck, link.si}),
      .q({s_cs_n, s_hold_n, s_sck, s_si})
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev_q <= 1'b1;
         sck_prev_q <= 1'b0;
      end else begin
         cs_prev_q <= s_cs_n;
         sck_prev_q <= s_sck;
      end
   end

   assign cs_fall = s_hold_n & cs_prev_q & ~s_cs_n;
   assign cs_rise = s_hold_n & ~cs_prev_q & s_cs_n;
   assign sck_rise = s_hold_n & ~s_cs_n & ~cs_prev_q & ~sck_prev_q & s_sck;
   assign sck_fall = s_hold_n & ~s_cs_n & sck_prev_q & ~s_sck;
   assign rx_d = {rx_q[6:0], s_si};
   assign byte_done = sck_rise & (cnt_q == `SFR_BIT_LAST);
   assign op_mem = (rx_d[7:4] == `SFR_OP_MEM_HI) &&
                   (rx_d[2:`SFR_OP_RD_BIT + 1] == `SFR_OP_MEM_LO);
   assign sts = {`SFR_SR_FILL, bp_q, write_enable_flag_q, 1'b0};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spi_mode3_q <= 1'b0;
      end else if (cs_fall) begin
         spi_mode3_q <= s_sck;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         rx_q <= '0;
      end else if (cs_fall) begin
         cnt_q <= '0;
      end else if (sck_rise) begin
         cnt_q <= cnt_q + 3'h1;
         rx_q <= rx_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= sfr_pkg::SFR_D_IDLE;
      end else if (cs_rise) begin
         st_q <= sfr_pkg::SFR_D_IDLE;
      end else if (cs_fall) begin
         st_q <= sfr_pkg::SFR_D_CMD;
      end else if (byte_done) begin
         unique case (st_q)
            sfr_pkg::SFR_D_CMD: begin
               if (rx_d == `SFR_OP_STS_RD) begin
                  st_q <= sfr_pkg::SFR_D_SROUT;
               end else if (rx_d == `SFR_OP_STS_WR) begin
                  st_q <= sfr_pkg::SFR_D_SRIN;
               end else if (op_mem) begin
                  st_q <= sfr_pkg::SFR_D_ADDR;
               end else begin
                  st_q <= sfr_pkg::SFR_D_IGNORE;
               end
            end
            sfr_pkg::SFR_D_ADDR: begin
               st_q <= is_read_q ? sfr_pkg::SFR_D_RDATA
                                 : sfr_pkg::SFR_D_WDATA;
            end
            sfr_pkg::SFR_D_SROUT, sfr_pkg::SFR_D_SRIN: begin
               st_q <= sfr_pkg::SFR_D_IGNORE;
            end
            sfr_pkg::SFR_D_IDLE, sfr_pkg::SFR_D_WDATA,
            sfr_pkg::SFR_D_RDATA, sfr_pkg::SFR_D_IGNORE: begin
               st_q <= st_q;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         write_enable_flag_q <= 1'b0;
         clr_pend_q <= 1'b0;
      end else if (cs_fall) begin
         clr_pend_q <= 1'b0;
      end else if (cs_rise) begin
         if (clr_pend_q) begin
            write_enable_flag_q <= 1'b0;
         end
      end else if (byte_done && st_q == sfr_pkg::SFR_D_CMD) begin
         if (rx_d == `SFR_OP_SET_LATCH) begin
            write_enable_flag_q <= 1'b1;
         end
         if (rx_d == `SFR_OP_CLR_LATCH || rx_d == `SFR_OP_STS_WR ||
             (op_mem && !rx_d[`SFR_OP_RD_BIT])) begin
            clr_pend_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bp_q <= '0;
         status_q <= '0;
      end else begin
         status_q <= sts;
         if (byte_done && st_q == sfr_pkg::SFR_D_SRIN &&
             write_enable_flag_q) begin
            bp_q <= rx_d[`SFR_SR_BP_HI:`SFR_SR_BP_LO];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_addr_q <= '0;
         is_read_q <= 1'b0;
         inc_q <= 1'b0;
      end else begin
         inc_q <= byte_done && (st_q == sfr_pkg::SFR_D_WDATA ||
                                st_q == sfr_pkg::SFR_D_RDATA);
         if (inc_q) begin
            mem_addr_q <= mem_addr_q + `SFR_ADDR_ONE;
         end else if (byte_done && st_q == sfr_pkg::SFR_D_CMD) begin
            mem_addr_q[8] <= rx_d[`SFR_OP_A8];
            is_read_q <= rx_d[`SFR_OP_RD_BIT];
         end else if (byte_done && st_q == sfr_pkg::SFR_D_ADDR) begin
            mem_addr_q[7:0] <= rx_d;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_we_q <= 1'b0;
         mem_re_q <= 1'b0;
         mem_wdata_q <= '0;
         load_q <= 1'b0;
      end else begin
         mem_we_q <= byte_done && st_q == sfr_pkg::SFR_D_WDATA &&
                     write_enable_flag_q;
         if (byte_done && st_q == sfr_pkg::SFR_D_WDATA) begin
            mem_wdata_q <= rx_d;
         end
         mem_re_q <= (byte_done && st_q == sfr_pkg::SFR_D_ADDR &&
                      is_read_q) ||
                     (inc_q && st_q == sfr_pkg::SFR_D_RDATA);
         load_q <= mem_re_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_q <= '0;
         link.so <= 1'b0;
      end else if (load_q) begin
         tx_q <= mem_rdata;
      end else if (byte_done && st_q == sfr_pkg::SFR_D_CMD) begin
         tx_q <= sts;
      end else if (sck_fall && (st_q == sfr_pkg::SFR_D_RDATA ||
                                st_q == sfr_pkg::SFR_D_SROUT)) begin
         link.so <= tx_q[7];
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.so_oe <= 1'b0;
      end else begin
         link.so_oe <= ~s_cs_n & ~cs_rise & s_hold_n &
                       (st_q == sfr_pkg::SFR_D_RDATA ||
                        st_q == sfr_pkg::SFR_D_SROUT);
      end
   end
endmodule

/* File: hw/sfr_host.sv */
// bus master end: frames one command of n bytes per start request
// assumes the user presents the next byte in tx_byte before tx_take
`timescale 1ns/1ps
`include "sfr_regs.svh"
module sfr_host (
   input wire logic clk,
   input wire logic rst_n,
   sfr_if.host link,
   input wire logic start,
   input wire logic mode3,
   input wire logic [7:0] nbytes,
   input wire logic [7:0] tx_byte,
   output logic tx_take_q,
   output logic [7:0] rx_byte_q,
   output logic rx_valid_q,
   output logic busy_q
);
   sfr_pkg::sfr_host_st_t st_q;
   logic [3:0] tmr_q;
   logic [2:0] bit_q;
   logic [7:0] left_q;
   logic [7:0] sh_q;
   logic [7:0] rsh_q;
   logic mode_q;
   logic so_s;
   logic tick;

   sfr_sync #(.W(1), .RST(1'b1)) u_so_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(link.miso),
      .q(so_s)
   );

   assign tick = (tmr_q == 4'h0);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link.hold_n <= 1'b0;
      end else begin
         link.hold_n <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= sfr_pkg::SFR_H_IDLE;
         tmr_q <= '0;
         bit_q <= '0;
         left_q <= '0;
         sh_q <= '0;
         rsh_q <= '0;
         mode_q <= 1'b0;
         link.cs_n <= 1'b1;
         link.sck <= 1'b0;
         link.si <= 1'b0;
         tx_take_q <= 1'b0;
         rx_byte_q <= '0;
         rx_valid_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         tx_take_q <= 1'b0;
         rx_valid_q <= 1'b0;
         tmr_q <= tick ? `SFR_HALF_CYC : tmr_q - 4'h1;
         unique case (st_q)
            sfr_pkg::SFR_H_IDLE: begin
               tmr_q <= `SFR_HALF_CYC;
               link.sck <= mode_q;
               if (start && nbytes != 8'h00) begin
                  mode_q <= mode3;
                  link.sck <= mode3;
                  // each command starts on select fall
                  link.cs_n <= 1'b0;
                  left_q <= nbytes;
                  busy_q <= 1'b1;
                  st_q <= sfr_pkg::SFR_H_LEAD;
               end
            end
            sfr_pkg::SFR_H_LEAD: begin
               if (tick) begin
                  link.sck <= 1'b0;
                  link.si <= tx_byte[7];
                  sh_q <= {tx_byte[6:0], 1'b0};
                  tx_take_q <= 1'b1;
                  bit_q <= '0;
                  st_q <= sfr_pkg::SFR_H_LOW;
               end
            end
            sfr_pkg::SFR_H_LOW: begin
               if (tick) begin
                  // half period fixed below top rate
                  link.sck <= 1'b1;
                  rsh_q <= {rsh_q[6:0], so_s};
                  st_q <= sfr_pkg::SFR_H_HIGH;
               end
            end
            sfr_pkg::SFR_H_HIGH: begin
               if (tick) begin
                  bit_q <= bit_q + 3'h1;
                  st_q <= sfr_pkg::SFR_H_LOW;
                  link.sck <= 1'b0;
                  link.si <= sh_q[7];
                  sh_q <= {sh_q[6:0], 1'b0};
                  if (bit_q == `SFR_BIT_LAST) begin
                     rx_byte_q <= rsh_q;
                     rx_valid_q <= 1'b1;
                     left_q <= left_q - 8'h01;
                     if (left_q == 8'h01) begin
                        link.sck <= mode_q;
                        st_q <= sfr_pkg::SFR_H_TRAIL;
                     end else begin
                        link.si <= tx_byte[7];
                        sh_q <= {tx_byte[6:0], 1'b0};
                        tx_take_q <= 1'b1;
                     end
                  end
               end
            end
            sfr_pkg::SFR_H_TRAIL: begin
               if (tick) begin
                  link.cs_n <= 1'b1;
                  st_q <= sfr_pkg::SFR_H_GAP;
               end
            end
            sfr_pkg::SFR_H_GAP: begin
               if (tick) begin
                  busy_q <= 1'b0;
                  st_q <= sfr_pkg::SFR_H_IDLE;
               end
            end
            default: begin
               st_q <= sfr_pkg::SFR_H_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: tb/sfr_link_properties.sv */
// concurrent checks on the serial link between the two ends
// assumes the link signals are wired in by name beside the interface
`timescale 1ns/1ps
module sfr_link_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic so,
   input wire logic so_oe,
   input wire logic miso
);
   logic sck_q;
   logic cs_n_q;
   logic [7:0] cnt_q;
   logic [7:0] op_q;
   logic rise;
   logic quiet;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // rising clock inside a selection, both samples selected
   assign rise = sck && !sck_q && !cs_n && !cs_n_q;
   // opcode that never answers on the output
   assign quiet = cnt_q >= 8'h08 && op_q != 8'h05 &&
      !(op_q[7:4] == 4'h0 && op_q[2:0] == 3'h3);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sck_q <= sck;
         cs_n_q <= cs_n;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
         op_q <= 8'h00;
      end else if (cs_n) begin
         cnt_q <= 8'h00;
      end else if (rise) begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q < 8'h08) begin
            op_q <= {op_q[6:0], si};
         end
      end
   end

   sequence s_sel_start;
      $fell(cs_n);
   endsequence

   sequence s_deselected;
      cs_n [*5];
   endsequence

   a_deselect_release: assert property (s_deselected |-> !so_oe)
      else $error("output enabled while deselected");
   a_output_on_fall: assert property (
      so_oe && $past(so_oe) && $changed(so) |-> !sck)
      else $error("output changed while clock high");
   a_sel_idle_clock: assert property (
      s_sel_start |=> $stable(sck) [*6])
      else $error("clock moved right after select");
   a_select_gap: assert property ($rose(cs_n) |-> cs_n [*4])
      else $error("select gap too short");
   a_unknown_silent: assert property (quiet |-> !so_oe && miso)
      else $error("output driven after silent opcode");
   a_clock_half_min: assert property (
      $changed(sck) |=> $stable(sck) [*3])
      else $error("clock half period too short");
   a_hold_inactive: assert property ($past(rst_n) |-> hold_n)
      else $error("hold asserted in normal run");
   a_whole_bytes: assert property (
      $rose(cs_n) |-> cnt_q[2:0] == 3'h0)
      else $error("frame ended inside a byte");
   a_answer_after_op: assert property (
      $rose(so_oe) |-> cnt_q >= 8'h08 && !cs_n)
      else $error("output enabled before opcode done");
endmodule

/* File: tb/tb_spi_memory_command_front_end.sv */
// top of the bench: both link ends face each other, table driven frames
// assumes the design files and the link checker are compiled first
`timescale 1ns/1ps
module tb_spi_memory_command_front_end;
   typedef struct {
      logic m3;
      int n;
      logic [31:0] b;
      logic latch;
      logic [7:0] rx;
   } sfr_row_t;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic start = 1'b0;
   logic mode3 = 1'b0;
   logic [7:0] nbytes = 8'h00;
   logic [7:0] tx_byte = 8'h00;
   logic [7:0] mem_rdata = 8'h00;
   logic tx_take_q, rx_valid_q, busy_q, mem_we_q, mem_re_q;
   logic latch_q, mode_q;
   logic [7:0] rx_byte_q, mem_wdata_q, status_q;
   logic [8:0] mem_addr_q;
   logic [7:0] mem [512];
   logic [7:0] rx [4];
   int bad_count = 0;
   int samples_checked = 0;
   sfr_row_t rows [21] = '{
      '{1'b0, 2, 32'h0500_0000, 1'b0, 8'h00},
      '{1'b1, 1, 32'h0600_0000, 1'b1, 8'hFF},
      '{1'b0, 2, 32'h0500_0000, 1'b1, 8'h02},
      '{1'b1, 2, 32'h010F_0000, 1'b0, 8'hFF},
      '{1'b0, 2, 32'h0500_0000, 1'b0, 8'h0C},
      '{1'b0, 2, 32'h0100_0000, 1'b0, 8'hFF},
      '{1'b1, 2, 32'h0500_0000, 1'b0, 8'h0C},
      '{1'b0, 1, 32'h0600_0000, 1'b1, 8'hFF},
      '{1'b1, 1, 32'h0400_0000, 1'b0, 8'hFF},
      '{1'b0, 2, 32'h0500_0000, 1'b0, 8'h0C},
      '{1'b0, 3, 32'h0210_7700, 1'b0, 8'hFF},
      '{1'b1, 3, 32'h0310_0000, 1'b0, 8'h00},
      '{1'b0, 1, 32'h0600_0000, 1'b1, 8'hFF},
      '{1'b1, 2, 32'h0100_0000, 1'b0, 8'hFF},
      '{1'b0, 1, 32'h0600_0000, 1'b1, 8'hFF},
      '{1'b1, 4, 32'h0AFF_A55A, 1'b0, 8'hFF},
      '{1'b0, 3, 32'h0BFF_0000, 1'b0, 8'hA5},
      '{1'b1, 4, 32'h0BFF_0000, 1'b0, 8'h5A},
      '{1'b0, 3, 32'h0300_0000, 1'b0, 8'h5A},
      '{1'b0, 4, 32'h8300_0000, 1'b0, 8'hFF},
      '{1'b0, 2, 32'h0500_0000, 1'b0, 8'h00}};

   sfr_if lnk ();

   sfr_dev i_sfr_dev (.clk(clk), .rst_n(rst_n), .link(lnk.dev),
      .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
      .mem_we_q(mem_we_q), .mem_re_q(mem_re_q), .mem_rdata(mem_rdata),
      .write_enable_flag_q(latch_q), .status_q(status_q),
      .spi_mode3_q(mode_q));

   sfr_host i_sfr_host (.clk(clk), .rst_n(rst_n), .link(lnk.host),
      .start(start), .mode3(mode3), .nbytes(nbytes), .tx_byte(tx_byte),
      .tx_take_q(tx_take_q), .rx_byte_q(rx_byte_q),
      .rx_valid_q(rx_valid_q), .busy_q(busy_q));

   sfr_link_properties i_sfr_link_properties (.clk(clk), .rst_n(rst_n),
      .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si), .hold_n(lnk.hold_n),
      .so(lnk.so), .so_oe(lnk.so_oe), .miso(lnk.miso));

   always #5 clk = ~clk;

   // byte memory on the user side, read data valid a cycle after request
   always @(negedge clk) begin
      if (mem_we_q) begin
         mem[mem_addr_q] <= mem_wdata_q;
      end
      if (mem_re_q) begin
         mem_rdata <= mem[mem_addr_q];
      end
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk_byte(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // one framed command, bytes taken from the top of b downwards
   task automatic frame(input logic m3, input int n, input logic [31:0] b);
      int i;
      int k;
      i = 0;
      k = 0;
      rx = '{4{8'hXX}};
      @(negedge clk);
      mode3 = m3;
      nbytes = 8'(n);
      tx_byte = b[31:24];
      start = 1'b1;
      for (int t = 0; t < 3000; t++) begin
         @(negedge clk);
         if (busy_q) begin
            start = 1'b0;
         end
         if (tx_take_q && i < 3) begin
            i++;
            tx_byte = b[31 - 8 * i -: 8];
         end
         if (rx_valid_q && k < 4) begin
            rx[k] = rx_byte_q;
            k++;
         end
         if (!start && !busy_q) begin
            return;
         end
      end
      bad_count++;
      $display("[FAIL] frame expected done seen hung");
      end_of_test();
   endtask

   initial begin
      for (int a = 0; a < 512; a++) begin
         mem[a] = 8'h00;
      end
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      foreach (rows[r]) begin
         frame(rows[r].m3, rows[r].n, rows[r].b);
         chk_byte("last rx", rows[r].rx, rx[rows[r].n - 1]);
         chk_bit("latch", rows[r].latch, latch_q);
         chk_bit("status flag", rows[r].latch, status_q[1]);
         chk_bit("mode", rows[r].m3, mode_q);
      end
      chk_byte("top byte", 8'hA5, mem[9'h1FF]);
      chk_byte("wrapped byte", 8'h5A, mem[9'h000]);
      chk_byte("blocked write", 8'h00, mem[9'h010]);
      // reset in mid write frame drops latch and select
      frame(1'b0, 1, 32'h0600_0000);
      @(negedge clk);
      nbytes = 8'h03;
      tx_byte = 8'h02;
      start = 1'b1;
      repeat (60) @(negedge clk);
      rst_n = 1'b0;
      start = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit("select", 1'b1, lnk.cs_n);
      chk_bit("latch", 1'b0, latch_q);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      frame(1'b0, 2, 32'h0500_0000);
      chk_byte("status", 8'h00, rx[1]);
      end_of_test();
   end
endmodule
